// ===== src/phid_pkg.sv
// Constants for the paged identification / vendor register block.
// Assumes a 40 MHz system clock and a 32-bit APB register port.
package phid_pkg;
	// APB byte addresses of the register window
	localparam logic [7:0] PHID_ADDR_PAGE_SEL = 8'h00;
	localparam logic [7:0] PHID_ADDR_PWR_CLASS = 8'h04;
	localparam logic [7:0] PHID_ADDR_STATUS = 8'h08;
	localparam logic [7:0] PHID_ADDR_PAGED_BASE = 8'h40;
	// Paged register indices (upper range 8..15)
	localparam logic [3:0] PHID_IDX_COMPLIANCE = 4'h8;
	localparam logic [3:0] PHID_IDX_OUI_HI = 4'hA;
	localparam logic [3:0] PHID_IDX_OUI_MID = 4'hB;
	localparam logic [3:0] PHID_IDX_OUI_LO = 4'hC;
	localparam logic [3:0] PHID_IDX_PROD_HI = 4'hD;
	localparam logic [3:0] PHID_IDX_PROD_MID = 4'hE;
	localparam logic [3:0] PHID_IDX_SOFT_RST = 4'hE;
	localparam logic [3:0] PHID_IDX_PROD_LO = 4'hF;
	// Page numbers
	localparam logic [2:0] PHID_PAGE_IDENT = 3'h1;
	localparam logic [2:0] PHID_PAGE_VENDOR = 3'h7;
	// Field positions and reset values
	localparam int PHID_SOFT_RST_BIT = 7;
	localparam logic [7:0] PHID_COMPLIANCE_VAL = 8'h02;
	localparam logic [2:0] PHID_PAGE_RST = 3'h0;
	localparam int PHID_PWR_LSB = 21;
	// Timing
	localparam int PHID_CLK_HZ = 40000000;
	localparam int PHID_RST_MIN_US = 2000;
	localparam int PHID_RST_MIN_CYC = (PHID_CLK_HZ / 1000000) * PHID_RST_MIN_US;
	localparam int PHID_SOFT_RST_CYC = 4;
	localparam int PHID_PCLK_DIV = 2;
	// Power-class codes
	typedef enum logic [2:0] {
		PHID_PC_NONE = 3'h0,
		PHID_PC_SELF15 = 3'h1,
		PHID_PC_SELF30 = 3'h2,
		PHID_PC_SELF5 = 3'h3,
		PHID_PC_BUS3 = 3'h4,
		PHID_PC_RSVD = 3'h5,
		PHID_PC_BUS3P3 = 3'h6,
		PHID_PC_BUS3P7 = 3'h7
	} phid_pwr_t;
endpackage : phid_pkg

// ===== src/phid_pclk_gen.sv
// Divided clock output used as a frequency-measurement tap.
// Assumes a synchronous, active-high reset on the same clock.
`timescale 1ns/10ps
`default_nettype none
module phid_pclk_gen #(
	parameter int DIV = 2
) (
	input wire logic mclk,
	input wire logic sys_rst,
	output logic clkOut
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic wrap;

	assign wrap = (cnt_r == 8'(DIV / 2 - 1));
	assign cnt_nxt = wrap ? 8'h00 : cnt_r + 8'h01;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cnt_r <= 8'h00;
			clkOut <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			if (wrap) begin
				clkOut <= ~clkOut;
			end
		end
	end
endmodule : phid_pclk_gen
`default_nettype wire

// ===== src/phid_regs.sv
// Paged identification / vendor page registers with power-class straps.
// Assumes an APB master on mclk and asynchronous strap and reset pins.
`timescale 1ns/10ps
`default_nettype none
//
// Behaviour
// - Page 1 index 8 reads a fixed compliance level of 02h.
// - The 24-bit maker OUI sits at indices 10-12, high byte first.
// - The 24-bit product code sits at indices 13-15, high byte first.
// - Writing 1 to the soft hard reset bit resets page select and power class; the APB answer and clock output keep running.
// - The soft hard reset bit always reads as 0.
// - Three strap pins give the default power class in self-ID bits 21-23.
// - Straps load after each hard reset; a later write overrides them.
// - Power-class codes carry the fixed meanings of the enum type.
// - A clock output derived from the internal clock is driven.
module phid_regs #(
	parameter logic [23:0] MAKER_OUI = 24'hA5A5A5,
	parameter logic [23:0] PRODUCT_CODE = 24'h5A5A5A
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic phyRst_n,
	input wire logic [2:0] powerClassStraps,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] selfIdPwrField,
	output logic phyInReset,
	output logic phyClkOut
);
	import phid_pkg::*;
	// Maker OUI and product code parameters are arbitrary neutral values.

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [1:0] rstPinSync_r;
	logic [2:0] strapSyncA_r;
	logic [2:0] strapSyncB_r;

	always_ff @(posedge mclk) begin
		rstPinSync_r <= {rstPinSync_r[0], phyRst_n};
		strapSyncA_r <= powerClassStraps;
		strapSyncB_r <= strapSyncA_r;
	end

	////////////////////////////////////////////////////////////////////////
	// Hard reset: pin, system reset or software request
	logic [2:0] softCnt_r;
	logic [2:0] softCnt_nxt;
	logic hardRst;
	logic softActive;
	logic softWrite;

	assign softActive = (softCnt_r != 3'h0);
	assign hardRst = sys_rst | ~rstPinSync_r[1] | softActive;

	assign softCnt_nxt = softWrite ? 3'(PHID_SOFT_RST_CYC)
		: (softActive ? softCnt_r - 3'h1 : 3'h0);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			softCnt_r <= 3'h0;
		end else begin
			softCnt_r <= softCnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB decode
	logic access;
	logic wrEn;
	logic rdEn;
	logic selPage;
	logic selPwr;
	logic selStat;
	logic selPaged;
	logic mapped;
	logic [3:0] pagedIdx;

	assign access = psel & penable;
	// Writes commit on the completing edge, once per transfer
	assign wrEn = access & pwrite & pready;
	assign rdEn = access & ~pwrite;
	assign selPage = (paddr == PHID_ADDR_PAGE_SEL);
	assign selPwr = (paddr == PHID_ADDR_PWR_CLASS);
	assign selStat = (paddr == PHID_ADDR_STATUS);
	assign pagedIdx = paddr[5:2];
	assign selPaged = (paddr[7:6] == PHID_ADDR_PAGED_BASE[7:6])
		& (paddr[1:0] == 2'b00) & pagedIdx[3];
	assign mapped = selPage | selPwr | selStat | selPaged;

	////////////////////////////////////////////////////////////////////////
	// Page select and power class
	logic [2:0] page_r;
	logic [2:0] page_nxt;
	phid_pwr_t pwrClass_r;
	phid_pwr_t pwrClass_nxt;
	logic strapLoad_r;

	assign page_nxt = (wrEn & selPage) ? pwdata[2:0] : page_r;
	assign softWrite = wrEn & selPaged & (page_r == PHID_PAGE_VENDOR)
		& (pagedIdx == PHID_IDX_SOFT_RST) & pwdata[PHID_SOFT_RST_BIT];
	assign pwrClass_nxt = strapLoad_r ? phid_pwr_t'(strapSyncB_r)
		: ((wrEn & selPwr) ? phid_pwr_t'(pwdata[2:0]) : pwrClass_r);

	always_ff @(posedge mclk) begin
		if (hardRst) begin
			page_r <= PHID_PAGE_RST;
			pwrClass_r <= PHID_PC_NONE;
			strapLoad_r <= 1'b1;
		end else begin
			page_r <= page_nxt;
			pwrClass_r <= pwrClass_nxt;
			strapLoad_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Paged read data
	function automatic logic [7:0] pagedRead(
		input logic [2:0] page,
		input logic [3:0] idx
	);
		logic [7:0] v;
		v = 8'h00;
		// Identification page only
		if (page == PHID_PAGE_IDENT) begin
			case (idx)
				PHID_IDX_COMPLIANCE: v = PHID_COMPLIANCE_VAL;
				PHID_IDX_OUI_HI: v = MAKER_OUI[23:16];
				PHID_IDX_OUI_MID: v = MAKER_OUI[15:8];
				PHID_IDX_OUI_LO: v = MAKER_OUI[7:0];
				PHID_IDX_PROD_HI: v = PRODUCT_CODE[23:16];
				PHID_IDX_PROD_MID: v = PRODUCT_CODE[15:8];
				PHID_IDX_PROD_LO: v = PRODUCT_CODE[7:0];
				default: v = 8'h00;
			endcase
		end
		return v;
	endfunction : pagedRead

	logic [31:0] rdMux;
	assign rdMux = selPage ? {29'h0, page_r}
		: selPwr ? {29'h0, pwrClass_r}
		: selStat ? {31'h0, hardRst}
		: selPaged ? {24'h0, pagedRead(page_r, pagedIdx)}
		: 32'h0;

	////////////////////////////////////////////////////////////////////////
	// APB answer: one wait state, ready in second access cycle
	logic ackPend_r;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			ackPend_r <= 1'b0;
		end else begin
			ackPend_r <= access & ~pready & ~ackPend_r;
			pready <= access & ~pready & ~ackPend_r;
			pslverr <= access & ~pready & ~ackPend_r & ~mapped;
			prdata <= (rdEn & ~pready) ? rdMux : 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			selfIdPwrField <= 32'h0;
			phyInReset <= 1'b1;
		end else begin
			selfIdPwrField <= {8'h00, pwrClass_r, 21'h0};
			phyInReset <= hardRst;
		end
	end

	phid_pclk_gen #(
		.DIV(PHID_PCLK_DIV)
	) uPclk (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clkOut(phyClkOut)
	);

	////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence s_softWr;
		wrEn & selPaged & (page_r == PHID_PAGE_VENDOR)
			& (pagedIdx == PHID_IDX_SOFT_RST) & pwdata[PHID_SOFT_RST_BIT];
	endsequence

	a_soft_reset_fires: assert property (
		@(posedge mclk) disable iff (sys_rst)
		s_softWr |=> ##1 phyInReset[*4])
		else $error("soft reset not applied");
	a_compliance_read: assert property (@(posedge mclk) disable iff (sys_rst)
		rdEn & ~pready & selPaged & (page_r == PHID_PAGE_IDENT)
		& (pagedIdx == PHID_IDX_COMPLIANCE) |=> prdata == 32'h2)
		else $error("compliance value wrong");
	a_oui_high: assert property (@(posedge mclk) disable iff (sys_rst)
		rdEn & ~pready & selPaged & (page_r == PHID_PAGE_IDENT)
		& (pagedIdx == PHID_IDX_OUI_HI) |=> prdata[7:0] == MAKER_OUI[23:16])
		else $error("oui high byte wrong");
	a_product_low: assert property (@(posedge mclk) disable iff (sys_rst)
		rdEn & ~pready & selPaged & (page_r == PHID_PAGE_IDENT)
		& (pagedIdx == PHID_IDX_PROD_LO) |=> prdata[7:0] == PRODUCT_CODE[7:0])
		else $error("product low byte wrong");
	a_soft_reads_zero: assert property (@(posedge mclk) disable iff (sys_rst)
		rdEn & ~pready & selPaged & (page_r == PHID_PAGE_VENDOR)
		|=> prdata == 32'h0) else $error("vendor page read not zero");
	a_strap_load: assert property (@(posedge mclk) disable iff (sys_rst)
		strapLoad_r & ~hardRst |=> pwrClass_r == $past(strapSyncB_r))
		else $error("strap not loaded");
	a_pwr_field: assert property (@(posedge mclk) disable iff (sys_rst)
		##1 selfIdPwrField[23:21] == $past(pwrClass_r))
		else $error("self-id power field wrong");
	a_ro_write: assert property (@(posedge mclk) disable iff (sys_rst)
		wrEn & selPaged & ~softWrite & ~hardRst & ~strapLoad_r
		|=> $stable(pwrClass_r) && $stable(page_r))
		else $error("read-only write changed state");
	a_apb_ready: assert property (@(posedge mclk) disable iff (sys_rst)
		psel & ~penable ##1 access |-> ##1 pready)
		else $error("ready not given");

	////////////////////////////////////////////////////////////////////////
	// Step sequences for the checks below
	sequence s_pagedRdStart;
		rdEn & ~pready & selPaged;
	endsequence

	sequence s_pwrWr;
		wrEn & selPwr & ~hardRst & ~strapLoad_r;
	endsequence

	sequence s_pageWr;
		wrEn & selPage & ~hardRst;
	endsequence

	sequence s_unmappedAcc;
		access & ~pready & ~mapped;
	endsequence

	sequence s_pinLow;
		~rstPinSync_r[1];
	endsequence

	////////////////////////////////////////////////////////////////////////
	// Identification and vendor page read-back
	a_oui_mid: assert property (
		@(posedge mclk) disable iff (sys_rst)
		s_pagedRdStart ##0 (page_r == PHID_PAGE_IDENT
		&& pagedIdx == PHID_IDX_OUI_MID)
		|=> prdata == {24'h0, MAKER_OUI[15:8]})
		else $error("oui middle byte wrong");
	a_oui_low: assert property (
		@(posedge mclk) disable iff (sys_rst)
		s_pagedRdStart ##0 (page_r == PHID_PAGE_IDENT
		&& pagedIdx == PHID_IDX_OUI_LO)
		|=> prdata == {24'h0, MAKER_OUI[7:0]})
		else $error("oui low byte wrong");
	a_product_high: assert property (
		@(posedge mclk) disable iff (sys_rst)
		s_pagedRdStart ##0 (page_r == PHID_PAGE_IDENT
		&& pagedIdx == PHID_IDX_PROD_HI)
		|=> prdata == {24'h0, PRODUCT_CODE[23:16]})
		else $error("product high byte wrong");
	a_product_mid: assert property (
		@(posedge mclk) disable iff (sys_rst)
		s_pagedRdStart ##0 (page_r == PHID_PAGE_IDENT
		&& pagedIdx == PHID_IDX_PROD_MID)
		|=> prdata == {24'h0, PRODUCT_CODE[15:8]})
		else $error("product middle byte wrong");
	a_soft_idx_zero: assert property (
		@(posedge mclk) disable iff (sys_rst)
		s_pagedRdStart ##0 (page_r == PHID_PAGE_VENDOR
		&& pagedIdx == PHID_IDX_SOFT_RST)
		|=> prdata[PHID_SOFT_RST_BIT] == 1'b0)
		else $error("soft reset bit read as one");

	////////////////////////////////////////////////////////////////////////
	// Power class
	a_pwr_override: assert property (
		@(posedge mclk) disable iff (sys_rst)
		s_pwrWr |=> pwrClass_r == $past(pwdata[2:0]))
		else $error("power class write lost");
	a_pwr_codes: assert property (
		@(posedge mclk) disable iff (sys_rst)
		s_pwrWr ##0 (pwdata[2:0] == PHID_PC_RSVD)
		|=> pwrClass_r == PHID_PC_RSVD)
		else $error("reserved power code not held");
	a_pwr_zero_bits: assert property (
		@(posedge mclk) disable iff (sys_rst)
		selfIdPwrField[31:24] == 8'h00
		&& selfIdPwrField[20:0] == 21'h0)
		else $error("self-id spare bits not zero");

	////////////////////////////////////////////////////////////////////////
	// Hard reset paths
	a_pin_reset: assert property (
		@(posedge mclk) disable iff (sys_rst)
		s_pinLow |=> phyInReset)
		else $error("pin reset not shown");
	a_rst_out: assert property (
		@(posedge mclk) disable iff (sys_rst)
		##1 phyInReset == $past(hardRst))
		else $error("reset output lags wrongly");
	a_hard_page_rst: assert property (
		@(posedge mclk) disable iff (sys_rst)
		hardRst |=> page_r == PHID_PAGE_RST)
		else $error("page kept through reset");
	a_soft_end: assert property (
		@(posedge mclk) disable iff (sys_rst)
		s_softWr |-> ##5 !softActive)
		else $error("soft reset did not end");

	////////////////////////////////////////////////////////////////////////
	// Register port behaviour
	a_page_write: assert property (
		@(posedge mclk) disable iff (sys_rst)
		s_pageWr |=> page_r == $past(pwdata[2:0]))
		else $error("page select write lost");
	a_unmapped_err: assert property (
		@(posedge mclk) disable iff (sys_rst)
		s_unmappedAcc |=> pslverr && pready)
		else $error("unmapped access not refused");
	a_pslverr_pair: assert property (
		@(posedge mclk) disable iff (sys_rst)
		pslverr |-> pready)
		else $error("error without ready");
	a_rd_idle: assert property (
		@(posedge mclk) disable iff (sys_rst)
		!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_ready_pulse: assert property (
		@(posedge mclk) disable iff (sys_rst)
		pready |=> !pready)
		else $error("ready longer than one cycle");

	a_clk_toggle: assert property (
		@(posedge mclk) disable iff (sys_rst)
		!sys_rst |=> phyClkOut != $past(phyClkOut))
		else $error("clock output stalled");
endmodule : phid_regs
`default_nettype wire

// ===== verif/phid_link_model.sv
// Link-side APB master reaching the paged registers.
// Assumes the slave answers with pready on a rising mclk edge.
`timescale 1ns/10ps
`default_nettype none
module phid_link_model (
	input wire logic mclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// Setup cycle, then access until pready
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd,
		output logic err, output logic tmo);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		tmo = 1'b1;
		for (n = 0; n < 16 && tmo; n++) begin
			@(posedge mclk);
			tmo = (pready !== 1'b1);
		end
		rd = prdata;
		err = pslverr;
		// Released bus shows no stale value
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~wd;
	endtask : xfer
endmodule : phid_link_model
`default_nettype wire

// ===== verif/test_phy_id_page_and_power_class.sv
// Self-checking bench for paged ident and power-class logic.
// Assumes phid_pkg, phid_regs and phid_link_model compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_phy_id_page_and_power_class;
	import phid_pkg::*;
	// Arbitrary identity values
	localparam logic [23:0] OUI = 24'h3C4D5E;
	localparam logic [23:0] PROD = 24'h6A7B8C;
	logic mclk, sys_rst, phyRst_n, psel, penable, pwrite, pready;
	logic pslverr, inRst, clkOut, err, tmo, prev;
	logic [2:0] straps, s;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, pwrField, rd;
	int nFail, numChecks, i;
	phid_regs #(.MAKER_OUI(OUI), .PRODUCT_CODE(PROD)) i_phid_regs (
		.mclk(mclk), .sys_rst(sys_rst), .phyRst_n(phyRst_n),
		.powerClassStraps(straps), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.selfIdPwrField(pwrField), .phyInReset(inRst),
		.phyClkOut(clkOut));
	phid_link_model i_phid_link_model (
		.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	function automatic logic [31:0] pwrWord(input logic [2:0] c);
		return {8'h00, c, 21'h000000};
	endfunction : pwrWord
	function automatic logic [7:0] pAddr(input logic [3:0] x);
		return 8'h40 | {2'b00, x, 2'b00};
	endfunction : pAddr
	function automatic logic [31:0] identWord(input logic [3:0] x);
		logic [63:0] t;
		t = {8'h02, 8'h00, OUI, PROD};
		return {24'h000000, t[8*(15-x) +: 8]};
	endfunction : identWord
	task automatic chk(input string nm, input logic [31:0] sn,
		input logic [31:0] ex);
		numChecks++;
		if (sn !== ex) begin
			nFail++;
			$display("mismatch %s expected %h seen %h", nm, ex, sn);
		end
	endtask : chk
	task automatic complete_run();
		$display("checks %0d mismatches %0d", numChecks, nFail);
		if (nFail == 0 && numChecks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run
	task automatic acc(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		i_phid_link_model.xfer(wr, a, wd, rd, err, tmo);
		if (tmo) begin
			nFail++;
			complete_run();
		end
	endtask : acc
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] ex);
		acc(1'b0, a, 32'h0);
		chk(nm, rd, ex);
	endtask : rdc
	task automatic waitLvl(input logic v);
		int n;
		for (n = 0; n < 64 && inRst !== v; n++)
			@(posedge mclk);
		if (inRst !== v) begin
			nFail++;
			complete_run();
		end
	endtask : waitLvl
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		sys_rst = 1'b1;
		phyRst_n = 1'b0;
		straps = 3'h6;
		nFail = 0;
		numChecks = 0;
		void'($urandom(18));
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (PHID_RST_MIN_CYC) @(posedge mclk);
		phyRst_n <= 1'b1;
		waitLvl(1'b0);
		repeat (2) @(posedge mclk);
		chk("pwrOut", pwrField, pwrWord(3'h6));
		rdc("stat", PHID_ADDR_STATUS, 32'h0);
		rdc("page", PHID_ADDR_PAGE_SEL, 32'h0);
		$display("test reset done");
		acc(1'b1, PHID_ADDR_PAGE_SEL, 32'h1);
		for (i = 8; i < 16; i++) begin
			rdc("ident", pAddr(i[3:0]), identWord(i[3:0]));
			acc(1'b1, pAddr(i[3:0]), $urandom);
			rdc("identWr", pAddr(i[3:0]), identWord(i[3:0]));
		end
		$display("test ident done");
		for (i = 0; i < 8; i++) begin
			acc(1'b1, PHID_ADDR_PWR_CLASS, 32'(i));
			repeat (2) @(posedge mclk);
			chk("pwrCode", pwrField, pwrWord(i[2:0]));
			rdc("pwrReg", PHID_ADDR_PWR_CLASS, 32'(i));
		end
		straps <= 3'($urandom);
		repeat (4) @(posedge mclk);
		chk("pwrKeep", pwrField, pwrWord(3'h7));
		acc(1'b0, 8'h0C, 32'h0);
		chk("slverr", {31'h0, err}, 32'h1);
		chk("badRd", rd, 32'h0);
		$display("test power done");
		for (i = 0; i < 2; i++) begin
			s = 3'($urandom);
			straps <= s;
			acc(1'b1, PHID_ADDR_PWR_CLASS, {29'h0, ~s});
			if (i == 0) begin
				phyRst_n <= 1'b0;
				repeat (4) @(posedge mclk);
				phyRst_n <= 1'b1;
			end else begin
				acc(1'b1, PHID_ADDR_PAGE_SEL, 32'h7);
				acc(1'b1, pAddr(PHID_IDX_SOFT_RST), 32'h7F);
				rdc("swrRd", pAddr(PHID_IDX_SOFT_RST), 32'h0);
				chk("noRst", {31'h0, inRst}, 32'h0);
				acc(1'b1, pAddr(PHID_IDX_SOFT_RST), 32'h80);
			end
			waitLvl(1'b1);
			waitLvl(1'b0);
			repeat (2) @(posedge mclk);
			chk("pwrLoad", pwrField, pwrWord(s));
			rdc("pageRst", PHID_ADDR_PAGE_SEL, 32'h0);
		end
		$display("test hard reset done");
		prev = clkOut;
		for (i = 0; i < 6; i++) begin
			@(posedge mclk);
			chk("pclk", {31'h0, clkOut}, {31'h0, ~prev});
			prev = clkOut;
		end
		$display("test clock done");
		complete_run();
	end
endmodule : test_phy_id_page_and_power_class
`default_nettype wire
